// File: verilog/srs_pkg.sv
// package for the serial readback selector: field layout, address codes, structs
package srs_pkg;
   localparam int SRS_FRAME_BITS = 16;
   localparam int SRS_DATA_BITS = 9;
   localparam logic [3:0] SRS_ADDR_STATUS = 4'h0;
   localparam logic [2:0] SRS_CODE_FAULT = 3'h1;
   localparam logic [2:0] SRS_CODE_PWM = 3'h2;
   localparam logic [2:0] SRS_CODE_LOAD_TYPE_SELECT = 3'h3;
   localparam logic [2:0] SRS_CODE_OCR = 3'h4;
   localparam logic [2:0] SRS_CODE_RETRY = 3'h5;
   localparam logic [3:0] SRS_ADDR_GLOBAL = 4'h6;
   localparam logic [3:0] SRS_ADDR_DIAG = 4'h7;
   localparam int SRS_BANK_BIT = 13;
   localparam int SRS_ECHO_LSB = 10;
   localparam int SRS_WD_BIT = 15;
   localparam int SRS_PF_BIT = 14;
   localparam int SRS_NM_BIT = 9;
   localparam logic [8:0] SRS_ZERO_DATA = 9'h000;
   localparam logic [3:0] SRS_RETRY_ZERO = 4'h0;
   localparam logic [1:0] SRS_LOAD_LAMP = 2'h0;

   // per-bank register contents seen by the readback
   typedef struct packed {
      logic [8:0] pulse_width_reg;
      logic [8:0] channel_config_reg;
      logic [8:0] overcurrent_reg;
      logic sense_offset_positive;
      logic retry_enable;
      logic [3:0] retry_count;
   } srs_bank_t;

   // common device state seen by the readback
   typedef struct packed {
      logic [8:0] global_config_reg;
      logic [8:0] status_reg;
      logic [1:0] load_type_select;
      logic clock_external;
      logic ext_clock_error;
      logic [1:0] cal_fail;
      logic normal_mode;
      logic watchdog_bit;
      logic parity_error;
   } srs_common_t;
endpackage

// File: verilog/srs_sync2.sv
// two-flop synchroniser for inputs arriving from outside the clk_sys domain
module srs_sync2 #(
   parameter int WIDTH = 1
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] stage1;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         stage1 <= '0;
         sync_out <= '0;
      end
      else
      begin
         stage1 <= async_in;
         sync_out <= stage1;
      end
   end
endmodule

// File: verilog/srs_readback.sv
// serial-output readback multiplexer: picks and shifts the addressed register
module srs_readback #(
   // arbitrary neutral value
   parameter logic [1:0] PRODUCT_ID = 2'h1
)(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_csb,
   input wire logic spi_si,
   input wire logic [1:0] direct_in,
   input wire srs_pkg::srs_bank_t bank0,
   input wire srs_pkg::srs_bank_t bank1,
   input wire srs_pkg::srs_common_t common,
   output logic spi_so,
   output logic spi_so_oe,
   output logic [3:0] readback_select,
   output logic frame_done
);
   import srs_pkg::*;

   // ----------------------------------------
   // pin synchronisation
   // ----------------------------------------
   logic [4:0] pins_sync;
   srs_sync2 #(.WIDTH(5)) u_sync (
      .clk_sys(clk_sys),
      .rst(rst),
      .async_in({spi_si, direct_in, spi_csb, spi_sclk}),
      .sync_out(pins_sync)
   );

   wire sclk_s = pins_sync[0];
   wire csb_s = pins_sync[1];
   wire [1:0] din_s = pins_sync[3:2];
   wire si_sync = pins_sync[4];

   // ----------------------------------------
   // edge detection
   // ----------------------------------------
   logic sclk_d;
   logic csb_d;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         sclk_d <= 1'b0;
      end
      else
      begin
         sclk_d <= sclk_s;
      end
   end

   // reset level matches the synchroniser's, so no false frame start after reset
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         csb_d <= 1'b0;
      end
      else
      begin
         csb_d <= csb_s;
      end
   end

   wire sclk_rise = sclk_s & ~sclk_d;
   wire sclk_fall = ~sclk_s & sclk_d;
   wire frame_start = ~csb_s & csb_d;
   wire frame_end = csb_s & ~csb_d;

   // ----------------------------------------
   // frame state
   // ----------------------------------------
   typedef enum logic [1:0] {ST_IDLE, ST_SHIFT} srs_state_t;
   srs_state_t state;
   srs_state_t next_state;
   always_comb
   begin
      next_state = ST_IDLE;
      case (state)
         ST_IDLE:
         begin
            if (frame_start)
               next_state = ST_SHIFT;
            else
               next_state = ST_IDLE;
         end
         ST_SHIFT:
         begin
            if (frame_end)
               next_state = ST_IDLE;
            else
               next_state = ST_SHIFT;
         end
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state <= ST_IDLE;
      end
      else
      begin
         state <= next_state;
      end
   end

   wire in_frame = (state == ST_SHIFT);
   wire shift_in = in_frame & sclk_rise;
   wire shift_out = in_frame & sclk_fall;
   wire frame_close = in_frame & frame_end;

   // ----------------------------------------
   // bank selection
   // ----------------------------------------
   wire bank_sel = readback_select[3];
   wire [2:0] code = readback_select[2:0];
   srs_bank_t bank_cur;
   assign bank_cur = bank_sel ? bank1 : bank0;

   // ----------------------------------------
   // retry counter view
   // ----------------------------------------
   // counter reads zero while auto-retry is off, whatever it last held
   wire [3:0] retry_field = bank_cur.retry_enable ? bank_cur.retry_count : SRS_RETRY_ZERO;
   wire [8:0] retry_view = {bank_cur.sense_offset_positive,
                            retry_field,
                            4'h0};

   // ----------------------------------------
   // diagnostic view
   // ----------------------------------------
   // clock error only counts while the external clock is the selected source
   wire ext_err = common.clock_external & common.ext_clock_error;
   wire [8:0] diag_view = {common.load_type_select[1],
                           common.load_type_select[0],
                           PRODUCT_ID,
                           din_s[1],
                           din_s[0],
                           ext_err,
                           common.cal_fail};

   // ----------------------------------------
   // address decode
   // ----------------------------------------
   wire hit_status = (readback_select == SRS_ADDR_STATUS);
   wire hit_global = (readback_select == SRS_ADDR_GLOBAL);
   wire hit_diag = (readback_select == SRS_ADDR_DIAG);
   wire hit_pwm = (code == SRS_CODE_PWM);
   wire hit_load_type_select = (code == SRS_CODE_LOAD_TYPE_SELECT);
   wire hit_ocr = (code == SRS_CODE_OCR);
   wire hit_retry = (code == SRS_CODE_RETRY);

   // hits are exclusive; fault and unused codes select nothing and read zero
   wire [8:0] sel_data = SRS_ZERO_DATA
                         | ({SRS_DATA_BITS{hit_status}} & common.status_reg)
                         | ({SRS_DATA_BITS{hit_global}} & common.global_config_reg)
                         | ({SRS_DATA_BITS{hit_diag}} & diag_view)
                         | ({SRS_DATA_BITS{hit_pwm}} & bank_cur.pulse_width_reg)
                         | ({SRS_DATA_BITS{hit_load_type_select}} & bank_cur.channel_config_reg)
                         | ({SRS_DATA_BITS{hit_ocr}} & bank_cur.overcurrent_reg)
                         | ({SRS_DATA_BITS{hit_retry}} & retry_view);

   // ----------------------------------------
   // output word
   // ----------------------------------------
   wire [15:0] out_word = {common.watchdog_bit,
                           common.parity_error,
                           readback_select,
                           common.normal_mode,
                           sel_data};

   // ----------------------------------------
   // transmit shifter
   // ----------------------------------------
   logic [15:0] tx_shift;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         tx_shift <= '0;
      end
      else if (frame_start)
      begin
         tx_shift <= out_word;
      end
      else if (shift_out)
      begin
         tx_shift <= {tx_shift[14:0], 1'b0};
      end
   end

   // ----------------------------------------
   // receive shifter
   // ----------------------------------------
   logic [15:0] rx_shift;
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         rx_shift <= '0;
      end
      else if (shift_in)
      begin
         rx_shift <= {rx_shift[14:0], si_sync};
      end
   end
   wire [3:0] next_select = {rx_shift[SRS_BANK_BIT], rx_shift[2:0]};

   // ----------------------------------------
   // bit counter
   // ----------------------------------------
   logic [4:0] bit_count;
   // saturates so an over-long frame never wraps back to a valid count
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         bit_count <= '0;
      end
      else if (frame_start)
      begin
         bit_count <= '0;
      end
      else if (shift_in && bit_count != '1)
      begin
         bit_count <= bit_count + 5'h1;
      end
   end
   wire frame_ok = (bit_count == 5'(SRS_FRAME_BITS));

   // ----------------------------------------
   // address capture
   // ----------------------------------------
   // address kept only from a complete frame; else last good selection stays
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         readback_select <= SRS_ADDR_STATUS;
      end
      else if (frame_close && frame_ok)
      begin
         readback_select <= next_select;
      end
   end

   // ----------------------------------------
   // output registers
   // ----------------------------------------
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         spi_so <= 1'b0;
      end
      else
      begin
         spi_so <= tx_shift[SRS_FRAME_BITS-1];
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         spi_so_oe <= 1'b0;
      end
      else
      begin
         spi_so_oe <= (next_state == ST_SHIFT);
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         frame_done <= 1'b0;
      end
      else
      begin
         frame_done <= frame_close;
      end
   end
endmodule

// File: dv/srs_readback_properties.sv
// checker of port timing for the readback selector
module srs_readback_checker (
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic spi_sclk,
   input wire logic spi_csb,
   input wire logic spi_so,
   input wire logic spi_so_oe,
   input wire logic [3:0] readback_select,
   input wire logic frame_done
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---
   // properties
   // ---
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (rst);
   property p_rst;
      disable iff (1'b0) rst |=> !spi_so_oe && !frame_done && readback_select == 4'h0;
   endproperty
   property p_oe_on;
      $fell(spi_csb) |-> ##[2:6] spi_so_oe;
   endproperty
   property p_oe_off;
      spi_csb [*6] |-> !spi_so_oe;
   endproperty
   property p_oe_hold;
      spi_so_oe && !spi_csb |=> spi_so_oe;
   endproperty
   property p_so_shift;
      spi_so_oe && $past(spi_so_oe) && $changed(spi_so) |-> !spi_sclk;
   endproperty
   property p_sel_idle;
      $changed(readback_select) |-> spi_csb;
   endproperty
   property p_done_pulse;
      frame_done |=> !frame_done;
   endproperty
   property p_quiet_after_rst;
      $fell(rst) |-> (!spi_so_oe && !frame_done) [*4];
   endproperty
   property p_done_after;
      frame_done |-> spi_csb && $past(spi_csb, 2);
   endproperty
   a_rst: assert property (p_rst) else $error("outputs not cleared in reset");
   a_oe_on: assert property (p_oe_on) else $error("output enable late");
   a_oe_off: assert property (p_oe_off) else $error("output enable outside frame");
   a_oe_hold: assert property (p_oe_hold) else $error("output enable dropped in frame");
   a_so_shift: assert property (p_so_shift) else $error("serial out moved while clock high");
   a_sel_idle: assert property (p_sel_idle) else $error("selection moved in frame");
   a_done_pulse: assert property (p_done_pulse) else $error("frame done too long");
   a_done_after: assert property (p_done_after) else $error("frame done without select high");
   a_quiet_after_rst: assert property (p_quiet_after_rst) else $error("false frame after reset");
   c_done: cover property (frame_done);
   c_oe: cover property ($rose(spi_so_oe));
   c_diag: cover property (frame_done ##[1:6] readback_select == 4'h7);
endmodule

bind srs_readback srs_readback_checker i_chk (.clk_sys(clk_sys), .rst(rst), .spi_sclk(spi_sclk), .spi_csb(spi_csb),
   .spi_so(spi_so), .spi_so_oe(spi_so_oe), .readback_select(readback_select), .frame_done(frame_done));

// File: dv/srs_spi_master.sv
// spi master model that clocks frames into the readback selector
module srs_spi_master (
   output logic spi_sclk,
   output logic spi_csb,
   output logic spi_si,
   input wire logic spi_so
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      spi_sclk = 1'b0;
      spi_csb = 1'b1;
      spi_si = 1'b0;
   end
   // ---
   // one frame of n bits, msb first; clock idles low
   // ---
   task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
      r = 16'h0000;
      #3.7 spi_csb = 1'b0;
      #200;
      for (int i = 0; i < n; i++)
      begin
         spi_si = w[15 - i];
         #62.5 spi_sclk = 1'b1;
         r = {r[14:0], spi_so};
         #62.5 spi_sclk = 1'b0;
      end
      #100 spi_csb = 1'b1;
      spi_si = ~spi_si; // released line shows the inverse
      #100;
   endtask
endmodule

// File: dv/tb_srs_readback.sv
// self-checking bench for the readback selector
module tb_srs_readback;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [1:0] PID = 2'h1; // arbitrary id value
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [1:0] din;
   srs_pkg::srs_bank_t b0, b1;
   srs_pkg::srs_common_t cm;
   logic sclk, csb, si, so, oe, done;
   logic [3:0] sel, pa;
   logic [15:0] rd;
   int failures = 0;
   int n_compared = 0;
   always #2.5 clk_sys = ~clk_sys;
   srs_readback #(.PRODUCT_ID(PID)) i_srs_readback (.clk_sys(clk_sys), .rst(rst), .spi_sclk(sclk), .spi_csb(csb),
      .spi_si(si), .direct_in(din), .bank0(b0), .bank1(b1), .common(cm), .spi_so(so), .spi_so_oe(oe),
      .readback_select(sel), .frame_done(done));
   srs_spi_master i_master (.spi_sclk(sclk), .spi_csb(csb), .spi_si(si), .spi_so(so));
   // ---
   // expectation and checking
   // ---
   function automatic logic [8:0] exp_data(input logic [3:0] a);
      srs_pkg::srs_bank_t b;
      b = a[3] ? b1 : b0;
      if (a == 4'h0) return cm.status_reg;
      if (a == 4'h6) return cm.global_config_reg;
      if (a == 4'h7) return {cm.load_type_select, PID, din, cm.clock_external & cm.ext_clock_error, cm.cal_fail};
      case (a[2:0])
         3'h2: return b.pulse_width_reg;
         3'h3: return b.channel_config_reg;
         3'h4: return b.overcurrent_reg;
         3'h5: return {b.sense_offset_positive, (b.retry_enable ? b.retry_count : 4'h0), 4'h0};
         default: return 9'h000;
      endcase
   endfunction
   task chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         failures++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task report_and_stop;
      $display("compared %0d failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task frame(input logic [3:0] a, input int n);
      logic [15:0] e;
      e = {cm.watchdog_bit, cm.parity_error, pa, cm.normal_mode, exp_data(pa)};
      i_master.xfer({2'b00, a[3], 10'h000, a[2:0]}, n, rd);
      chk("frame", rd, e >> (16 - n));
      chk("select", {12'h000, sel}, {12'h000, ((n == 16) ? a : pa)});
      if (n == 16) pa = a;
   endtask
   // ---
   // tests
   // ---
   initial
   begin
      din = 2'h2;
      b0 = {9'h1a5, 9'h0c3, 9'h15a, 1'b1, 1'b0, 4'h9};
      b1 = {9'h05e, 9'h1f0, 9'h033, 1'b0, 1'b1, 4'h5};
      cm = {9'h111, 9'h0aa, 2'h1, 1'b1, 1'b1, 2'h2, 1'b1, 1'b0, 1'b0};
      pa = 4'h0;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      for (int p = 0; p < 2; p++)
      begin
         for (int a = 0; a < 16; a++)
            frame(a[3:0], 16);
         @(posedge clk_sys);
         b0.retry_enable <= 1'b1;
         din <= 2'h1;
         cm.clock_external <= 1'b0;
         cm.cal_fail <= 2'h1;
         cm.load_type_select <= 2'h2;
      end
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (8) @(posedge clk_sys);
      rst <= 1'b0;
      repeat (6) @(posedge clk_sys);
      pa = 4'h0;
      chk("reset select", {12'h000, sel}, 16'h0000);
      frame(4'h6, 8);
      frame(4'hd, 16);
      frame(4'h2, 16);
      report_and_stop;
   end
   initial
   begin
      #400us;
      failures++;
      report_and_stop;
   end
endmodule
